// ---- design/dvt_cfg.svh ----
// Register map, field positions, reset values and timing counts of the video timing block
// How it works
// - Low-power command bit forbids high-speed commands
// - End-of-frame ack bit requests acknowledge each frame
// - Six enables allow low-power return when time allows
// - Type 00 pulses, 01 events, 1x burst
// - Fourteen-bit pixels per video packet
// - Thirteen-bit chunk count per line
// - Thirteen-bit null packet size in bytes
// - Twelve-bit horizontal sync width in byte cycles
// - Twelve-bit horizontal back porch in byte cycles
// - Fifteen-bit total line length in byte cycles
// - Ten-bit vertical sync length in lines
// - Ten-bit vertical back porch in lines
// - Ten-bit vertical front porch in lines
// - Frames start only while video enable set; a started frame runs to its end
// - Fourteen-bit active lines after back porch
// - Low-power commands capped by region byte limits
`ifndef DVT_CFG_SVH
`define DVT_CFG_SVH

// ****************************************
// Register byte offsets
// ****************************************
`define DVT_LP_CMD_TIM_OFS   8'h18
`define DVT_MODE_OFS         8'h34
`define DVT_VM_CFG_OFS       8'h38
`define DVT_PKT_PIX_OFS      8'h3c
`define DVT_CHUNKS_OFS       8'h40
`define DVT_NULL_OFS         8'h44
`define DVT_HSA_OFS          8'h48
`define DVT_HBP_OFS          8'h4c
`define DVT_HLINE_OFS        8'h50
`define DVT_VSA_OFS          8'h54
`define DVT_VBP_OFS          8'h58
`define DVT_VFP_OFS          8'h5c
`define DVT_VACT_OFS         8'h60
`define DVT_HACT_OFS         8'h80
`define DVT_STATUS_OFS       8'h84

// ****************************************
// Field positions and masks
// ****************************************
`define DVT_VM_LP_CMD        15
`define DVT_VM_EOF_ACK       14
`define DVT_VM_LP_HFP        13
`define DVT_VM_LP_HBP        12
`define DVT_VM_LP_VACT       11
`define DVT_VM_LP_VFP        10
`define DVT_VM_LP_VBP        9
`define DVT_VM_LP_VSA        8
`define DVT_VM_CFG_MASK      32'h0000_ff03
`define DVT_LP_CMD_MASK      32'h00ff_00ff

// ****************************************
// Reset value and timing counts
// ****************************************
`define DVT_RST_ZERO         32'h0000_0000
`define DVT_LP_OVERHEAD_CYC  16

`endif

// ---- design/dvt_pkg.sv ----
// Types shared by the video timing block
package dvt_pkg;
  // Vertical region of the frame
  typedef enum logic [2:0] {VS_IDLE, VS_SYNC, VS_BP, VS_ACT, VS_FP} dvt_vst_e;
  // Packet issued toward the lanes
  typedef enum logic [2:0] {PK_NONE, PK_VSS, PK_VSE, PK_HSS, PK_HSE, PK_VIDEO, PK_NULL} dvt_pkt_e;
endpackage : dvt_pkg

// ---- design/dvt_video_timing.sv ----
// Video-mode line and frame sequencer with Avalon-MM register slave
`timescale 1ns/1ns
`default_nettype none
`include "dvt_cfg.svh"

module dvt_video_timing #(
  parameter int unsigned LP_OVERHEAD = `DVT_LP_OVERHEAD_CYC
) (
  input  wire logic              ref_clk,
  input  wire logic              rst_n,
  input  wire logic [7:0]        avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire logic [31:0]       avs_writedata,
  input  wire logic [3:0]        avs_byteenable,
  output var  logic [31:0]       avs_readdata,
  output var  logic              avs_waitrequest,
  input  wire logic              lane_byte_clk,
  output var  logic              lp_mode,
  output var  logic              pkt_strobe,
  output var  dvt_pkg::dvt_pkt_e pkt_type,
  output var  logic [13:0]       pkt_pixels,
  output var  logic [12:0]       pkt_null_bytes,
  output var  logic              frame_end,
  output var  logic              end_of_frame_ack_request,
  output var  logic              cmd_lp_only,
  output var  logic              cmd_hs_ok,
  output var  logic [7:0]        cmd_max_bytes
);
  import dvt_pkg::*;

  // ****************************************
  // Registers
  // ****************************************
  logic        wait_q, en_video_q, null_turn_q, lp_q, pk_stb_q, fend_q, ack_q, cmd_lp_q, cmd_hs_q;
  logic        bclk_s1_q, bclk_s2_q, bclk_s3_q;
  logic [31:0] rdata_q;
  logic [15:0] vm_cfg_q;
  logic [13:0] pix_q, vact_q, v_cnt_q;
  logic [14:0] hline_q, hact_q, h_cnt_q;
  logic [12:0] chunks_q, null_q, chunk_q;
  logic [11:0] hsa_q, hbp_q;
  logic [9:0]  vsa_q, vbp_q, vfp_q;
  logic [7:0]  lp_out_q, lp_in_q, cmd_max_q;
  dvt_vst_e    v_st_q;
  dvt_pkt_e    pk_ty_q;

  logic [31:0] rd_val, wr_val, be_mask;
  logic        wr_take, tick;

  // ****************************************
  // Avalon-MM slave
  // ****************************************
  // Byte enables widen to a bit mask for read-modify-write
  assign be_mask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}}, {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
  assign wr_val  = (rd_val & ~be_mask) | (avs_writedata & be_mask);
  assign wr_take = avs_write && !wait_q;

  // Read mux; reserved bits and unmapped words read zero
  always_comb begin
    rd_val = `DVT_RST_ZERO;
    case (avs_address)
      `DVT_LP_CMD_TIM_OFS: rd_val = {8'h00, lp_out_q, 8'h00, lp_in_q};
      `DVT_MODE_OFS:       rd_val = {31'h0000_0000, en_video_q};
      `DVT_VM_CFG_OFS:     rd_val = {16'h0000, vm_cfg_q};
      `DVT_PKT_PIX_OFS:    rd_val = {18'h00000, pix_q};
      `DVT_CHUNKS_OFS:     rd_val = {19'h00000, chunks_q};
      `DVT_NULL_OFS:       rd_val = {19'h00000, null_q};
      `DVT_HSA_OFS:        rd_val = {20'h00000, hsa_q};
      `DVT_HBP_OFS:        rd_val = {20'h00000, hbp_q};
      `DVT_HLINE_OFS:      rd_val = {17'h00000, hline_q};
      `DVT_VSA_OFS:        rd_val = {22'h000000, vsa_q};
      `DVT_VBP_OFS:        rd_val = {22'h000000, vbp_q};
      `DVT_VFP_OFS:        rd_val = {22'h000000, vfp_q};
      `DVT_VACT_OFS:       rd_val = {18'h00000, vact_q};
      `DVT_HACT_OFS:       rd_val = {17'h00000, hact_q};
      `DVT_STATUS_OFS:     rd_val = {11'h000, v_st_q, v_cnt_q, 3'h0, lp_q};
      default:             rd_val = `DVT_RST_ZERO;
    endcase
  end

  // One wait cycle per access; data latched so it stands at the accept edge
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      wait_q  <= 1'b1;
      rdata_q <= `DVT_RST_ZERO;
    end else begin
      wait_q <= !((avs_read || avs_write) && wait_q);
      if (avs_read && wait_q) begin
        rdata_q <= rd_val;
      end
    end
  end

  // Configuration writes; everything clears to zero at reset
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      en_video_q <= 1'b0;
      vm_cfg_q   <= 16'h0000;
      pix_q      <= 14'h0000;
      chunks_q   <= 13'h0000;
      null_q     <= 13'h0000;
      hsa_q      <= 12'h000;
      hbp_q      <= 12'h000;
      hline_q    <= 15'h0000;
      vsa_q      <= 10'h000;
      vbp_q      <= 10'h000;
      vfp_q      <= 10'h000;
      vact_q     <= 14'h0000;
      lp_out_q   <= 8'h00;
      lp_in_q    <= 8'h00;
      hact_q     <= 15'h0000;
    end else if (wr_take) begin
      case (avs_address)
        `DVT_LP_CMD_TIM_OFS: begin
          lp_out_q <= wr_val[23:16];
          lp_in_q  <= wr_val[7:0];
        end
        `DVT_MODE_OFS:    en_video_q <= wr_val[0];
        `DVT_VM_CFG_OFS:  vm_cfg_q   <= 16'(wr_val & `DVT_VM_CFG_MASK);
        `DVT_PKT_PIX_OFS: pix_q      <= wr_val[13:0];
        `DVT_CHUNKS_OFS:  chunks_q   <= wr_val[12:0];
        `DVT_NULL_OFS:    null_q     <= wr_val[12:0];
        `DVT_HSA_OFS:     hsa_q      <= wr_val[11:0];
        `DVT_HBP_OFS:     hbp_q      <= wr_val[11:0];
        `DVT_HLINE_OFS:   hline_q    <= wr_val[14:0];
        `DVT_VSA_OFS:     vsa_q      <= wr_val[9:0];
        `DVT_VBP_OFS:     vbp_q      <= wr_val[9:0];
        `DVT_VFP_OFS:     vfp_q      <= wr_val[9:0];
        `DVT_VACT_OFS:    vact_q     <= wr_val[13:0];
        `DVT_HACT_OFS:    hact_q     <= wr_val[14:0];
        default: ;
      endcase
    end
  end

  // ****************************************
  // Lane byte clock sampling
  // ****************************************
  // Two flops then an edge detector; the first flop feeds only the second
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      {bclk_s3_q, bclk_s2_q, bclk_s1_q} <= 3'h0;
    end else begin
      {bclk_s3_q, bclk_s2_q, bclk_s1_q} <= {bclk_s2_q, bclk_s1_q, lane_byte_clk};
    end
  end
  assign tick = bclk_s2_q && !bclk_s3_q;

  // ****************************************
  // Line and frame timing
  // ****************************************
  // Line count of each vertical region
  function automatic logic [13:0] v_len(input dvt_vst_e s);
    case (s)
      VS_SYNC: v_len = {4'h0, vsa_q};
      VS_BP:   v_len = {4'h0, vbp_q};
      VS_ACT:  v_len = vact_q;
      VS_FP:   v_len = {4'h0, vfp_q};
      default: v_len = 14'h0000;
    endcase
  endfunction : v_len

  // Next non-empty region in sync, porch, active, porch order; wrap marks frame end
  function automatic dvt_vst_e v_next(input dvt_vst_e st, output logic wrap);
    dvt_vst_e s;
    logic     done;
    s    = st;
    wrap = 1'b0;
    done = 1'b0;
    for (int k = 0; k < 4; k++) begin
      if (!done) begin
        case (s)
          VS_SYNC: s = VS_BP;
          VS_BP:   s = VS_ACT;
          VS_ACT:  s = VS_FP;
          default: begin
            s    = VS_SYNC;
            wrap = 1'b1;
          end
        endcase
        done = (v_len(s) != 14'h0000);
      end
    end
    v_next = s;
  endfunction : v_next

  logic [14:0] h_last;
  logic [15:0] act_start, act_end, h_ext;
  logic        running, line_end, reg_end, wrap, wrap0;
  dvt_vst_e    nxt_st, first_st;

  // Front porch is whatever the line leaves after sync, porch and active
  assign h_last    = (hline_q == 15'h0000) ? 15'h0000 : hline_q - 15'h0001;
  assign act_start = {4'h0, hsa_q} + {4'h0, hbp_q};
  assign act_end   = act_start + {1'b0, hact_q};
  assign h_ext     = {1'b0, h_cnt_q};
  assign running   = (v_st_q != VS_IDLE);
  assign line_end  = running && tick && (h_cnt_q >= h_last);

  // Region lookups run procedurally so they follow every timing register they read
  always_comb begin
    reg_end  = (v_cnt_q + 14'h0001 >= v_len(v_st_q));
    nxt_st   = v_next(v_st_q, wrap);
    first_st = v_next(VS_FP, wrap0);
  end

  // Region sequencer; a frame starts only with video enabled
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      v_st_q  <= VS_IDLE;
      v_cnt_q <= 14'h0000;
      h_cnt_q <= 15'h0000;
    end else if (!running) begin
      h_cnt_q <= 15'h0000;
      v_cnt_q <= 14'h0000;
      if (en_video_q && tick) begin
        v_st_q <= first_st;
      end
    end else if (line_end) begin
      h_cnt_q <= 15'h0000;
      if (reg_end) begin
        v_cnt_q <= 14'h0000;
        v_st_q  <= (wrap && !en_video_q) ? VS_IDLE : nxt_st;
      end else begin
        v_cnt_q <= v_cnt_q + 14'h0001;
      end
    end else if (tick) begin
      h_cnt_q <= h_cnt_q + 15'h0001;
    end
  end

  // ****************************************
  // Packet scheduling
  // ****************************************
  logic        pulse_mode, burst, chunk_go, pk_go;
  logic [12:0] n_chunks;
  dvt_pkt_e    pk_ty;

  assign pulse_mode = (vm_cfg_q[1:0] == 2'b00);
  assign burst      = vm_cfg_q[1];
  assign n_chunks   = (chunks_q == 13'h0000) ? 13'h0001 : chunks_q;
  assign chunk_go   = (v_st_q == VS_ACT) && (h_ext >= act_start) && (h_ext < act_end)
                      && (chunk_q < n_chunks);

  // One packet per byte cycle: sync start, sync end (pulse mode only), then chunks
  always_comb begin
    pk_go = 1'b0;
    pk_ty = PK_NONE;
    if (running && tick) begin
      if (h_cnt_q == 15'h0000) begin
        pk_go = 1'b1;
        pk_ty = (v_st_q == VS_SYNC) ? PK_VSS : PK_HSS;
      end else if (pulse_mode && (h_cnt_q == {3'h0, hsa_q})) begin
        pk_go = 1'b1;
        pk_ty = (v_st_q == VS_SYNC) ? PK_VSE : PK_HSE;
      end else if (chunk_go) begin
        pk_go = 1'b1;
        pk_ty = (!burst && null_turn_q && (null_q != 13'h0000)) ? PK_NULL : PK_VIDEO;
      end
    end
  end

  // Chunk count and video/null alternation restart each line
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      chunk_q     <= 13'h0000;
      null_turn_q <= 1'b0;
    end else if (line_end || !running) begin
      chunk_q     <= 13'h0000;
      null_turn_q <= 1'b0;
    end else if (pk_go && (pk_ty == PK_VIDEO || pk_ty == PK_NULL)) begin
      chunk_q     <= chunk_q + 13'h0001;
      null_turn_q <= !null_turn_q;
    end
  end

  // ****************************************
  // Low-power return and command window
  // ****************************************
  logic [15:0] rem;
  logic        lp_en, lp_d;

  // Remaining byte cycles of the current region and its enable
  always_comb begin
    rem   = 16'h0000;
    lp_en = 1'b0;
    if (v_st_q != VS_ACT) begin
      rem = {1'b0, hline_q} - h_ext;
      unique case (v_st_q)
        VS_SYNC: lp_en = vm_cfg_q[`DVT_VM_LP_VSA];
        VS_BP:   lp_en = vm_cfg_q[`DVT_VM_LP_VBP];
        VS_FP:   lp_en = vm_cfg_q[`DVT_VM_LP_VFP];
        VS_IDLE: lp_en = 1'b1;
      endcase
      lp_en = lp_en && (h_cnt_q >= {3'h0, hsa_q} || !running);
    end else if (h_cnt_q < {3'h0, hsa_q}) begin
      rem   = {4'h0, hsa_q} - h_ext;
      lp_en = vm_cfg_q[`DVT_VM_LP_VACT];
    end else if (h_ext < act_start) begin
      rem   = act_start - h_ext;
      lp_en = vm_cfg_q[`DVT_VM_LP_HBP];
    end else if (h_ext < act_end) begin
      rem   = {1'b0, hline_q} - h_ext;
      lp_en = burst && (chunk_q >= n_chunks) && vm_cfg_q[`DVT_VM_LP_HFP];
    end else begin
      rem   = {1'b0, hline_q} - h_ext;
      lp_en = vm_cfg_q[`DVT_VM_LP_HFP];
    end
  end

  // Lanes drop to low power when idle, or when the region leaves time to come back
  assign lp_d = !running || (lp_en && !pk_go && (rem > 16'(LP_OVERHEAD)));

  // Lane state, packet strobe and frame end pulses
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      lp_q     <= 1'b1;
      pk_stb_q <= 1'b0;
      pk_ty_q  <= PK_NONE;
      fend_q   <= 1'b0;
      ack_q    <= 1'b0;
    end else begin
      lp_q     <= lp_d;
      pk_stb_q <= pk_go;
      pk_ty_q  <= pk_ty;
      fend_q   <= line_end && reg_end && wrap;
      ack_q    <= line_end && reg_end && wrap && vm_cfg_q[`DVT_VM_EOF_ACK];
    end
  end

  // Command window; a separate byte cap (lp_in_q) applies inside active lines
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      cmd_lp_q  <= 1'b0;
      cmd_hs_q  <= 1'b0;
      cmd_max_q <= 8'h00;
    end else begin
      cmd_lp_q  <= vm_cfg_q[`DVT_VM_LP_CMD];
      cmd_hs_q  <= !vm_cfg_q[`DVT_VM_LP_CMD] && !lp_d && running && !pk_go;
      cmd_max_q <= !lp_d ? 8'h00 : (v_st_q == VS_ACT) ? lp_in_q : lp_out_q;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign avs_readdata             = rdata_q;
  assign avs_waitrequest          = wait_q;
  assign lp_mode                  = lp_q;
  assign pkt_strobe               = pk_stb_q;
  assign pkt_type                 = pk_ty_q;
  assign pkt_pixels               = pix_q;
  assign pkt_null_bytes           = null_q;
  assign frame_end                = fend_q;
  assign end_of_frame_ack_request = ack_q;
  assign cmd_lp_only              = cmd_lp_q;
  assign cmd_hs_ok                = cmd_hs_q;
  assign cmd_max_bytes            = cmd_max_q;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  bus_answer_a: assert property ((avs_read || avs_write) && wait_q |=> !wait_q)
    else $error("waitrequest did not drop after one cycle");
  mode_write_a: assert property (wr_take && avs_address == `DVT_MODE_OFS && avs_byteenable[0]
    |=> en_video_q == $past(avs_writedata[0]))
    else $error("video enable write lost");
  idle_hold_a: assert property (!running && !en_video_q |=> !running)
    else $error("frame started with video disabled");
  eof_ack_a: assert property (ack_q |-> fend_q && vm_cfg_q[`DVT_VM_EOF_ACK])
    else $error("acknowledge request outside frame end");
  lp_cmd_a: assert property (vm_cfg_q[`DVT_VM_LP_CMD] |=> !cmd_hs_q)
    else $error("high-speed command allowed in low-power-only mode");
  sync_end_a: assert property (pk_stb_q && (pk_ty_q == PK_HSE || pk_ty_q == PK_VSE) |-> $past(pulse_mode))
    else $error("sync end packet outside pulse mode");
  null_burst_a: assert property (pk_go && pk_ty == PK_NULL |-> !burst && null_q != 13'h0000)
    else $error("null packet in burst mode");
  chunk_cap_a: assert property (chunk_q <= n_chunks)
    else $error("too many chunks in a line");
  line_wrap_a: assert property (line_end |=> h_cnt_q == 15'h0000)
    else $error("line counter did not wrap");
  lp_room_a: assert property (running ##1 lp_q |-> $past(rem) > 16'(LP_OVERHEAD))
    else $error("low-power return without room");
  cmd_cap_a: assert property (!lp_q |-> cmd_max_q == 8'h00)
    else $error("command bytes allowed in high speed");

  frame_done_c: cover property (fend_q);
  video_pkt_c: cover property (pk_stb_q && pk_ty_q == PK_VIDEO);
  null_pkt_c: cover property (pk_stb_q && pk_ty_q == PK_NULL);
  lp_active_c: cover property (lp_q && v_st_q == VS_ACT);

endmodule : dvt_video_timing
`default_nettype wire

// ---- tb/dvt_display_model.sv ----
// Display-side model: lane byte clock source and tally of received traffic
`timescale 1ns/1ns
`default_nettype none
module dvt_display_model (
  input  wire logic              ref_clk,
  input  wire logic              run,
  input  wire logic              clr,
  output var  logic              lane_byte_clk,
  input  wire logic              pkt_strobe,
  input  wire dvt_pkg::dvt_pkt_e pkt_type,
  input  wire logic              frame_end,
  input  wire logic              end_of_frame_ack_request,
  input  wire logic              lp_mode,
  input  wire logic              cmd_hs_ok,
  output var  logic [7:0][15:0]  pkt_cnt,
  output var  int                frames,
  output var  int                acks,
  output var  int                lp_cyc,
  output var  int                hs_cyc
);
  import dvt_pkg::*;
  logic running;
  // Byte clock stands still while run is low; odd start offset keeps it unrelated in phase
  initial begin
    lane_byte_clk = 1'b0;
    #137;
    forever begin
      #400;
      lane_byte_clk = run ? ~lane_byte_clk : 1'b0;
    end
  end
  // Tally packets, frame ends and lane states seen inside a frame
  always @(posedge ref_clk) begin
    if (clr) begin
      pkt_cnt <= '0;
      frames  <= 0;
      acks    <= 0;
      lp_cyc  <= 0;
      hs_cyc  <= 0;
      running <= 1'b0;
    end else begin
      if (pkt_strobe) begin
        pkt_cnt[pkt_type] <= pkt_cnt[pkt_type] + 16'h1;
        running           <= 1'b1;
      end
      if (frame_end) begin
        frames  <= frames + 1;
        running <= 1'b0;
      end
      if (end_of_frame_ack_request) acks <= acks + 1;
      if (running && !frame_end && lp_mode) lp_cyc <= lp_cyc + 1;
      if (cmd_hs_ok) hs_cyc <= hs_cyc + 1;
    end
  end
endmodule : dvt_display_model
`default_nettype wire

// ---- tb/dvt_video_timing_tb.sv ----
// Self-checking bench for the video timing sequencer
`timescale 1ns/1ns
`default_nettype none
`include "dvt_cfg.svh"
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin errors++; $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end

module dvt_video_timing_tb;
  import dvt_pkg::*;
  // ****************************************
  // Frame geometry and signals
  // ****************************************
  localparam int VSA = 1, VBP = 1, VACT = 2, VFP = 1, CHUNKS = 2;
  logic ref_clk, rst_n, avs_read, avs_write, avs_waitrequest, lane_byte_clk, lp_mode, run, clr;
  logic pkt_strobe, frame_end, eof_ack, cmd_lp_only, cmd_hs_ok;
  logic [7:0]  avs_address, cmd_max_bytes;
  logic [31:0] avs_writedata, avs_readdata, rdata, cfg;
  logic [3:0]  avs_byteenable;
  logic [13:0] pkt_pixels;
  logic [12:0] pkt_null_bytes;
  dvt_pkt_e    pkt_type;
  logic [7:0][15:0] pkt_cnt;
  int          frames, acks, lp_cyc, hs_cyc, errors, checked;
  logic [31:0] rnd = 32'h8;
  logic [7:0]  offs [10] = '{`DVT_VM_CFG_OFS, `DVT_PKT_PIX_OFS, `DVT_CHUNKS_OFS, `DVT_NULL_OFS, `DVT_HSA_OFS,
                             `DVT_HBP_OFS, `DVT_HLINE_OFS, `DVT_VSA_OFS, `DVT_VBP_OFS, `DVT_VFP_OFS};
  logic [31:0] masks [10] = '{32'hff03, 32'h3fff, 32'h1fff, 32'h1fff, 32'hfff, 32'hfff, 32'h7fff,
                              32'h3ff, 32'h3ff, 32'h3ff};

  dvt_video_timing #(.LP_OVERHEAD(2)) uut (.ref_clk(ref_clk), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .lane_byte_clk(lane_byte_clk),
    .lp_mode(lp_mode), .pkt_strobe(pkt_strobe), .pkt_type(pkt_type), .pkt_pixels(pkt_pixels),
    .pkt_null_bytes(pkt_null_bytes), .frame_end(frame_end), .end_of_frame_ack_request(eof_ack),
    .cmd_lp_only(cmd_lp_only), .cmd_hs_ok(cmd_hs_ok), .cmd_max_bytes(cmd_max_bytes));

  dvt_display_model disp (.ref_clk(ref_clk), .run(run), .clr(clr), .lane_byte_clk(lane_byte_clk),
    .pkt_strobe(pkt_strobe), .pkt_type(pkt_type), .frame_end(frame_end), .end_of_frame_ack_request(eof_ack),
    .lp_mode(lp_mode), .cmd_hs_ok(cmd_hs_ok), .pkt_cnt(pkt_cnt), .frames(frames), .acks(acks),
    .lp_cyc(lp_cyc), .hs_cyc(hs_cyc));

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [31:0] xs();
    rnd = rnd ^ (rnd << 13);
    rnd = rnd ^ (rnd >> 17);
    rnd = rnd ^ (rnd << 5);
    return rnd;
  endfunction : xs

  // Packets per frame of kind k for transmission type t
  function automatic int exp_pkt(input int t, input int k);
    case (k)
      1: return VSA;
      2: return (t == 0) ? VSA : 0;
      3: return VBP + VACT + VFP;
      4: return (t == 0) ? VBP + VACT + VFP : 0;
      5: return (t >= 2) ? VACT * CHUNKS : VACT * ((CHUNKS + 1) / 2);
      6: return (t >= 2) ? 0 : VACT * (CHUNKS / 2);
      default: return 0;
    endcase
  endfunction : exp_pkt

  // One bus cycle, held until waitrequest is seen low; the bound only guards a hang
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
    int n;
    @(posedge ref_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= be;
    avs_write <= wr;
    avs_read <= ~wr;
    n = 0;
    @(posedge ref_clk);
    while (avs_waitrequest !== 1'b0 && n < 20) begin
      @(posedge ref_clk);
      n++;
    end
    `CHK(avs_waitrequest, 1'b0)
    rdata = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus

  task automatic tally_and_finish;
    $display("checked=%0d errors=%0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : tally_and_finish

  // ****************************************
  // Clock, watchdog and test sequence
  // ****************************************
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  initial begin
    #3_000_000;
    errors++;
    tally_and_finish();
  end

  initial begin
    int n;
    logic [31:0] v;
    {rst_n, avs_read, avs_write, run, clr} = '0;
    avs_address = '0;
    avs_writedata = '0;
    avs_byteenable = '0;
    repeat (10) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(negedge ref_clk);
    `CHK(lp_mode, 1'b1)
    `CHK(pkt_type, PK_NONE)
    for (int i = 0; i < 10; i++) begin
      bus(1'b0, offs[i], 32'h0, 4'hf);
      `CHK(rdata, `DVT_RST_ZERO)
    end
    // Random readback shows field widths and reserved bits
    for (int r = 0; r < 3; r++)
      for (int i = 0; i < 10; i++) begin
        v = xs();
        if (i == 1) v = v & 32'hffff_fffc;
        bus(1'b1, offs[i], v, 4'hf);
        bus(1'b0, offs[i], 32'h0, 4'hf);
        `CHK(rdata, v & masks[i])
      end
    bus(1'b1, `DVT_HLINE_OFS, 32'h0, 4'hf);
    bus(1'b1, `DVT_HLINE_OFS, 32'hffff_ffff, 4'h1);
    bus(1'b0, `DVT_HLINE_OFS, 32'h0, 4'hf);
    `CHK(rdata, 32'h0000_00ff)
    bus(1'b1, 8'h70, 32'hffff_ffff, 4'hf);
    bus(1'b0, 8'h70, 32'h0, 4'hf);
    `CHK(rdata, 32'h0)
    // Small frame: 12-cycle lines, 2+2 sync and porch, 4 active, 4 left for front porch
    bus(1'b1, `DVT_PKT_PIX_OFS, 32'h4, 4'hf);
    bus(1'b1, `DVT_CHUNKS_OFS, CHUNKS, 4'hf);
    bus(1'b1, `DVT_NULL_OFS, 32'h3, 4'hf);
    bus(1'b1, `DVT_HSA_OFS, 32'h2, 4'hf);
    bus(1'b1, `DVT_HBP_OFS, 32'h2, 4'hf);
    bus(1'b1, `DVT_HACT_OFS, 32'h4, 4'hf);
    bus(1'b1, `DVT_HLINE_OFS, 32'hc, 4'hf);
    bus(1'b1, `DVT_VSA_OFS, VSA, 4'hf);
    bus(1'b1, `DVT_VBP_OFS, VBP, 4'hf);
    bus(1'b1, `DVT_VACT_OFS, VACT, 4'hf);
    bus(1'b1, `DVT_VFP_OFS, VFP, 4'hf);
    bus(1'b1, `DVT_LP_CMD_TIM_OFS, 32'hff33_aa44, 4'hf);
    bus(1'b0, `DVT_LP_CMD_TIM_OFS, 32'h0, 4'hf);
    `CHK(rdata, 32'h0033_0044)
    for (int t = 0; t < 4; t++) begin
      cfg = t[0] ? 32'h7f00 : 32'h8000;
      cfg[1:0] = t[1:0];
      bus(1'b1, `DVT_VM_CFG_OFS, cfg, 4'hf);
      repeat (2) @(posedge ref_clk);
      `CHK(cmd_lp_only, cfg[15])
      `CHK(pkt_pixels, 14'h4)
      `CHK(pkt_null_bytes, 13'h3)
      clr <= 1'b1;
      run <= 1'b1;
      @(posedge ref_clk);
      clr <= 1'b0;
      bus(1'b1, `DVT_MODE_OFS, 32'h1, 4'hf);
      // Enable drops once the frame is under way, so exactly one frame completes and idles
      n = 0;
      while (pkt_strobe !== 1'b1 && n < 300) begin
        @(posedge ref_clk);
        n++;
      end
      bus(1'b1, `DVT_MODE_OFS, 32'h0, 4'hf);
      n = 0;
      while (frames == 0 && n < 3000) begin
        @(posedge ref_clk);
        n++;
      end
      repeat (20) @(posedge ref_clk);
      run <= 1'b0;
      `CHK(frames, 1)
      `CHK(acks, int'(cfg[14]))
      for (int k = 1; k < 7; k++)
        `CHK(int'(pkt_cnt[k]), exp_pkt(t, k))
      `CHK(lp_cyc > 0, cfg[13])
      if (cfg[15]) `CHK(hs_cyc, 0)
      `CHK(lp_mode, 1'b1)
      `CHK(cmd_max_bytes, 8'h33)
      $display("test type %0d done", t);
    end
    tally_and_finish();
  end
endmodule : dvt_video_timing_tb
`default_nettype wire
